// file: wdtm_map.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes:   definitions only
`ifndef WDTM_MAP_SVH
`define WDTM_MAP_SVH

`define WDTM_ADDR_W          8
`define WDTM_OFF_CONTROL     8'h30
`define WDTM_OFF_STATUS      8'h34
`define WDTM_OFF_IRQ_STAT    8'h38
`define WDTM_OFF_IRQ_CLR     8'h3C
`define WDTM_OFF_IRQ_EN      8'h40

// control register fields
`define WDTM_CTL_SWEN_BIT    0
`define WDTM_CTL_PS_LSB      1
`define WDTM_CTL_PS_W        5
`define WDTM_CTL_RESET       8'h16
// status register fields
`define WDTM_ST_TO_BIT       0
`define WDTM_ST_PD_BIT       1
`define WDTM_ST_ACT_BIT      2
`define WDTM_ST_SLEEP_BIT    3
// interrupt event bits
`define WDTM_EV_W            2
`define WDTM_EV_TIMEOUT      0
`define WDTM_EV_WAKE         1

// prescale codes: period = 1 ms << code, 0..18 (1 ms .. 262 s)
`define WDTM_PS_MAX          5'd18
`define WDTM_CNT_W           19

// slow oscillator and base tick
`define WDTM_OSC_HZ          31000
`define WDTM_TICK_US         1000
`define WDTM_OSC_PER_TICK    ((`WDTM_OSC_HZ * `WDTM_TICK_US) / 1000000)
`define WDTM_CLK_MHZ         250

`endif

// file: wdtm_pkg.sv
// Purpose: types shared by the watchdog files
// Assumes: constants come from wdtm_map.svh
// Notes:   none
package wdtm_pkg;
    typedef enum logic [1:0] {
        WDTM_MODE_OFF    = 2'b00,
        WDTM_MODE_SOFT   = 2'b01,
        WDTM_MODE_NOSLP  = 2'b10,
        WDTM_MODE_ALWAYS = 2'b11
    } wdtm_mode_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wdtm_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wdtm_wb_rsp_t;

    typedef struct packed {
        logic sleep;
        logic kick;
        logic osc_fail;
    } wdtm_core_evt_t;
endpackage : wdtm_pkg

// file: wdtm_tick.sv
// Purpose: slow oscillator model and 1 ms base tick generator
// Assumes: core_clk at 250 MHz
// Notes:   slow edges come from a divider of core_clk, so no crossing
`timescale 1ns/1ps
`include "wdtm_map.svh"
module wdtm_tick #(
    parameter int OSC_DIV  = (`WDTM_CLK_MHZ * 1000000) / `WDTM_OSC_HZ,
    parameter int PER_TICK = `WDTM_OSC_PER_TICK
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic clk_en,
    // tick out
    output logic      tick_1ms
);
    import wdtm_pkg::*;

    typedef struct packed {
        logic [15:0] div;
        logic [7:0]  osc;
        logic        tick;
    } wdtm_tick_st_t;

    wdtm_tick_st_t st_q;
    wdtm_tick_st_t st_d;

    // oscillator advances only while clk_en is high; sysclk_divider_chg does not reach it
    always_comb begin
        st_d      = st_q;
        st_d.tick = 1'b0;
        if (st_q.div == 16'(OSC_DIV - 1)) begin
            st_d.div = '0;
            if (st_q.osc == 8'(PER_TICK - 1)) begin
                st_d.osc  = '0;
                st_d.tick = 1'b1;
            end else begin
                st_d.osc = st_q.osc + 8'h01;
            end
        end else begin
            st_d.div = st_q.div + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign tick_1ms = st_q.tick;
endmodule : wdtm_tick

// file: wdtm_top.sv
// Purpose: watchdog with four configured modes and sleep behaviour
// Assumes: wishbone classic slave, sync active-high reset
// Notes:   mode comes from the configuration word input, not a register
`timescale 1ns/1ps
`include "wdtm_map.svh"
module wdtm_top #(
    parameter int OSC_DIV  = (`WDTM_CLK_MHZ * 1000000) / `WDTM_OSC_HZ,
    parameter int PER_TICK = `WDTM_OSC_PER_TICK
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic                  clk_en,
    // configuration word field
    input  wire wdtm_pkg::wdtm_mode_t  wdt_mode_cfg,
    // core events
    input  wire wdtm_pkg::wdtm_core_evt_t core_evt,
    input  wire logic                  sysclk_divider_chg,
    // wishbone
    input  wire wdtm_pkg::wdtm_wb_req_t wb_req,
    output wdtm_pkg::wdtm_wb_rsp_t     wb_rsp,
    // outputs to core
    output logic                       wdt_reset_req,
    output logic                       wdt_wake_req,
    output logic                       watchdog_expired_flag,
    output logic                       power_down_flag,
    output logic                       irq
);
    import wdtm_pkg::*;

    typedef struct packed {
        logic                      swen;
        logic [`WDTM_CTL_PS_W-1:0] ps;
        logic [`WDTM_CNT_W-1:0]    cnt;
        logic                      active;
        logic                      sleep;
        logic                      to_flag;
        logic                      pd_flag;
        logic                      rst_req;
        logic                      wake_req;
        logic [`WDTM_EV_W-1:0]     ev_stat;
        logic [`WDTM_EV_W-1:0]     ev_en;
        logic                      irq;
        wdtm_wb_rsp_t              rsp;
    } wdtm_state_t;

    wdtm_state_t st_q;
    wdtm_state_t st_d;
    logic        tick_1ms;

    wdtm_tick #(
        .OSC_DIV  (OSC_DIV),
        .PER_TICK (PER_TICK)
    ) u_tick (
        .core_clk (core_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .tick_1ms (tick_1ms)
    );

    // activity decode, applied to the incoming sleep state sleep_in only
    function automatic logic wdt_active(input wdtm_mode_t m,
                                        input logic swen,
                                        input logic asleep);
        unique case (m)
            WDTM_MODE_ALWAYS: wdt_active = 1'b1;
            WDTM_MODE_NOSLP:  wdt_active = !asleep;
            WDTM_MODE_SOFT:   wdt_active = swen;
            WDTM_MODE_OFF:    wdt_active = 1'b0;
        endcase
    endfunction : wdt_active

    // period in ticks minus one, code saturated at 18 (262 s)
    function automatic logic [`WDTM_CNT_W-1:0] period_last(
        input logic [`WDTM_CTL_PS_W-1:0] code);
        logic [`WDTM_CTL_PS_W-1:0] c;
        c = (code > `WDTM_PS_MAX) ? `WDTM_PS_MAX : code;
        period_last = (`WDTM_CNT_W'(1) << c) - `WDTM_CNT_W'(1);
    endfunction : period_last

    logic       acc;
    logic       acc_wr;
    logic       acc_rd;
    logic [7:0] adr;
    logic       act_now;
    logic       expire;
    logic       sleep_in;
    logic       sleep_chg;
    logic [`WDTM_EV_W-1:0] ev_set;
    logic [31:0] rdata;

    always_comb begin
        st_d  = st_q;
        adr   = wb_req.adr;
        acc   = wb_req.cyc && wb_req.stb && !st_q.rsp.ack;
        acc_wr = acc && wb_req.we;
        acc_rd = acc && !wb_req.we;
        rdata = '0;
        ev_set = '0;

        // --- register bus ---
        st_d.rsp.ack = acc;
        unique case (adr)
            `WDTM_OFF_CONTROL: begin
                rdata[`WDTM_CTL_SWEN_BIT] = st_q.swen;
                rdata[`WDTM_CTL_PS_LSB +: `WDTM_CTL_PS_W] = st_q.ps;
                if (acc_wr && wb_req.sel[0]) begin
                    st_d.swen = wb_req.dat[`WDTM_CTL_SWEN_BIT];
                    st_d.ps   = wb_req.dat[`WDTM_CTL_PS_LSB +:
                                           `WDTM_CTL_PS_W];
                end
            end
            `WDTM_OFF_STATUS: begin
                rdata[`WDTM_ST_TO_BIT]    = st_q.to_flag;
                rdata[`WDTM_ST_PD_BIT]    = st_q.pd_flag;
                rdata[`WDTM_ST_ACT_BIT]   = st_q.active;
                rdata[`WDTM_ST_SLEEP_BIT] = st_q.sleep;
            end
            `WDTM_OFF_IRQ_STAT: rdata[`WDTM_EV_W-1:0] = st_q.ev_stat;
            `WDTM_OFF_IRQ_EN: begin
                rdata[`WDTM_EV_W-1:0] = st_q.ev_en;
                if (acc_wr && wb_req.sel[0]) begin
                    st_d.ev_en = wb_req.dat[`WDTM_EV_W-1:0];
                end
            end
            default: rdata = '0;
        endcase
        if (acc_wr && adr == `WDTM_OFF_IRQ_CLR && wb_req.sel[0]) begin
            st_d.ev_stat = st_q.ev_stat & ~wb_req.dat[`WDTM_EV_W-1:0];
        end
        st_d.rsp.dat = acc_rd ? rdata : '0;

        // --- sleep tracking; a watchdog wake ends sleep ---
        sleep_in  = core_evt.sleep && !st_q.wake_req;
        st_d.sleep = sleep_in;
        sleep_chg = sleep_in != st_q.sleep;
        act_now   = wdt_active(wdt_mode_cfg, st_d.swen, sleep_in);
        st_d.active = act_now;

        // --- counter ---
        st_d.rst_req  = 1'b0;
        st_d.wake_req = 1'b0;
        // at or past the end: a shorter prescale written mid-count still fires
        expire = act_now && tick_1ms && (st_q.cnt >= period_last(st_q.ps));
        // divider changes are ignored on purpose
        if (!act_now || core_evt.kick || core_evt.osc_fail
            || sleep_chg) begin
            st_d.cnt = '0;
        end else if (expire) begin
            st_d.cnt = '0;
            if (st_q.sleep) begin
                st_d.wake_req = 1'b1;
                st_d.to_flag  = 1'b1;
                st_d.pd_flag  = 1'b1;
            end else begin
                st_d.rst_req = 1'b1;
                st_d.to_flag = 1'b1;
            end
            ev_set[`WDTM_EV_TIMEOUT] = 1'b1;
            ev_set[`WDTM_EV_WAKE]    = st_q.sleep;
        end else if (tick_1ms) begin
            st_d.cnt = st_q.cnt + `WDTM_CNT_W'(1);
        end
        // a kick restarts the expiry flag history
        if (core_evt.kick) begin
            st_d.to_flag = 1'b0;
        end
        if (sleep_in && !st_q.sleep) begin
            st_d.pd_flag = 1'b1;
        end

        // set wins over a clear in the same cycle
        st_d.ev_stat = st_d.ev_stat | ev_set;
        st_d.irq = |(st_d.ev_stat & st_d.ev_en);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q         <= '0;
            st_q.ps      <= `WDTM_CTL_PS_W'(`WDTM_CTL_RESET >>
                                            `WDTM_CTL_PS_LSB);
            st_q.swen    <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign wb_rsp                = st_q.rsp;
    assign wdt_reset_req         = st_q.rst_req;
    assign wdt_wake_req          = st_q.wake_req;
    assign watchdog_expired_flag = st_q.to_flag;
    assign power_down_flag       = st_q.pd_flag;
    assign irq                   = st_q.irq;
endmodule : wdtm_top

// file: wdtm_assertions.sv
// Purpose: port-level checks of the watchdog pulses and flags
// Assumes: bound to wdtm_top, one clock domain
// Notes:   periods are judged by the bench
`timescale 1ns/1ps
module wdtm_assertions (
    // clock and reset
    input wire logic                     core_clk,
    input wire logic                     rst,
    // inputs
    input wire wdtm_pkg::wdtm_mode_t     wdt_mode_cfg,
    input wire wdtm_pkg::wdtm_core_evt_t core_evt,
    input wire wdtm_pkg::wdtm_wb_req_t   wb_req,
    // outputs
    input wire wdtm_pkg::wdtm_wb_rsp_t   wb_rsp,
    input wire logic                     wdt_reset_req,
    input wire logic                     wdt_wake_req,
    input wire logic                     watchdog_expired_flag,
    input wire logic                     power_down_flag
);
    import wdtm_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_take;
        wb_req.cyc && wb_req.stb && !wb_rsp.ack;
    endsequence
    sequence s_ack_once;
        wb_rsp.ack ##1 !wb_rsp.ack;
    endsequence
    chk_ack_one: assert property (s_take |=> s_ack_once)
        else $error("ack not a single pulse one cycle after request");
    chk_off_quiet: assert property (wdt_mode_cfg == WDTM_MODE_OFF &&
        $past(wdt_mode_cfg) == WDTM_MODE_OFF |-> !wdt_reset_req && !wdt_wake_req)
        else $error("watchdog fired while off");
    chk_sleep_no_reset: assert property (core_evt.sleep &&
        $past(core_evt.sleep) |-> !wdt_reset_req)
        else $error("reset raised during sleep");
    chk_awake_no_wake: assert property (!core_evt.sleep &&
        !$past(core_evt.sleep) |-> !wdt_wake_req)
        else $error("wake raised while awake");
    chk_reset_flag: assert property (wdt_reset_req &&
        !$past(core_evt.kick) |-> watchdog_expired_flag)
        else $error("reset without expiry flag");
    chk_wake_flags: assert property (wdt_wake_req |->
        watchdog_expired_flag && power_down_flag)
        else $error("wake without both flags");
    chk_kick_clear: assert property (core_evt.kick |=>
        !watchdog_expired_flag || wdt_reset_req || wdt_wake_req)
        else $error("kick left expiry flag set");
    chk_pulse_single: assert property (wdt_reset_req || wdt_wake_req
        |=> !wdt_reset_req && !wdt_wake_req)
        else $error("timeout pulse longer than one cycle");
    chk_pd_sticky: assert property (power_down_flag |=> power_down_flag)
        else $error("power-down flag dropped without reset");
endmodule : wdtm_assertions

// file: watchdog_timer_modes_tb.sv
// Purpose: self-checking bench for the watchdog modes and sleep
// Assumes: tick of 4 cycles with OSC_DIV=2, PER_TICK=2
// Notes:   code 3 gives 8 ticks, about 32 cycles
`timescale 1ns/1ps
`include "wdtm_map.svh"
module watchdog_timer_modes_tb;
    import wdtm_pkg::*;
    logic           core_clk = 0, rst = 1, clk_en = 1, div_chg = 0;
    wdtm_mode_t     mode = WDTM_MODE_OFF;
    wdtm_core_evt_t evt = '0;
    wdtm_wb_req_t   req = '0;
    wdtm_wb_rsp_t   rsp;
    logic           rst_req, wake_req, exp_f, pd_f, irq, hit;
    logic [31:0]    q;
    int             n_fail = 0, compares = 0, cycles = 0;
    always #2 core_clk = ~core_clk;
    wdtm_top #(.OSC_DIV(2), .PER_TICK(2)) wdtm_top_i (
        .core_clk(core_clk), .rst(rst), .clk_en(clk_en),
        .wdt_mode_cfg(mode), .core_evt(evt), .sysclk_divider_chg(div_chg),
        .wb_req(req), .wb_rsp(rsp), .wdt_reset_req(rst_req),
        .wdt_wake_req(wake_req), .watchdog_expired_flag(exp_f),
        .power_down_flag(pd_f), .irq(irq));
    task results;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            results();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // classic cycle: hold until ack is sampled, then idle one cycle
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
        do @(posedge core_clk); while (rsp.ack !== 1'b1);
        q = rsp.dat;
        req <= '0;
        @(posedge core_clk);
    endtask : wb
    task clr(input bit osc);
        if (osc) evt.osc_fail <= 1'b1;
        else evt.kick <= 1'b1;
        @(posedge core_clk);
        evt.osc_fail <= 1'b0;
        evt.kick <= 1'b0;
    endtask : clr
    // stops at the first pulse so sleep can be dropped on wake
    task wait_evt(input bit wake, input int n);
        hit = 0;
        for (int i = 0; i < n && !hit; i++) begin
            @(posedge core_clk);
            if ((wake ? wake_req : rst_req) === 1'b1) hit = 1;
        end
    endtask : wait_evt
    task t_reset;
        wb(0, `WDTM_OFF_CONTROL, 0); chk(q, 32'h16);
        wb(0, `WDTM_OFF_STATUS, 0); chk(q, 32'h0);
        wb(1, 8'h20, 32'hFF); wb(0, 8'h20, 0); chk(q, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task t_modes;
        logic act;
        for (int m = 0; m < 4; m++)
            for (int s = 0; s < 2; s++)
                for (int e = 0; e < 2; e++) begin
                    mode <= wdtm_mode_t'(m[1:0]);
                    evt.sleep <= s[0];
                    wb(1, `WDTM_OFF_CONTROL, 32'h16 | e);
                    wb(0, `WDTM_OFF_STATUS, 0);
                    act = m == 3 || (m == 2 && s == 0) || (m == 1 && e == 1);
                    chk(q[`WDTM_ST_ACT_BIT], act);
                end
        evt.sleep <= 1'b0;
        $display("test modes done");
    endtask : t_modes
    task t_awake;
        mode <= WDTM_MODE_NOSLP;
        wb(1, `WDTM_OFF_IRQ_EN, 32'h1);
        wb(1, `WDTM_OFF_CONTROL, 32'h06);
        div_chg <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            clr(i == 3);
            wait_evt(0, 24); chk(hit, 0);
        end
        div_chg <= 1'b0;
        wait_evt(0, 20); chk(hit, 1);
        @(posedge core_clk);
        chk(exp_f, 1);
        chk(irq, 1);
        mode <= WDTM_MODE_OFF;
        wait_evt(0, 40); chk(hit, 0);
        wb(1, `WDTM_OFF_IRQ_CLR, 32'h1);
        wb(0, `WDTM_OFF_IRQ_STAT, 0); chk(q[0], 0);
        chk(irq, 0);
        clr(0);
        @(posedge core_clk);
        chk(exp_f, 0);
        $display("test awake done");
    endtask : t_awake
    task t_sleep;
        mode <= WDTM_MODE_ALWAYS;
        wb(1, `WDTM_OFF_IRQ_EN, 32'h3);
        clr(0);
        evt.sleep <= 1'b1;
        wait_evt(1, 50); chk(hit, 1);
        evt.sleep <= 1'b0;
        @(posedge core_clk);
        chk(pd_f, 1);
        chk(exp_f, 1);
        wb(0, `WDTM_OFF_IRQ_STAT, 0); chk(q[1], 1);
        chk(irq, 1);
        mode <= WDTM_MODE_NOSLP;
        evt.sleep <= 1'b1;
        wait_evt(1, 60); chk(hit, 0);
        evt.sleep <= 1'b0;
        wait_evt(0, 24); chk(hit, 0);
        mode <= WDTM_MODE_OFF;
        $display("test sleep done");
    endtask : t_sleep
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset;
        t_modes;
        t_awake;
        t_sleep;
        results;
    end
endmodule : watchdog_timer_modes_tb
bind wdtm_top wdtm_assertions wdtm_assertions_i (
    .core_clk(core_clk), .rst(rst), .wdt_mode_cfg(wdt_mode_cfg),
    .core_evt(core_evt), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .wdt_reset_req(wdt_reset_req), .wdt_wake_req(wdt_wake_req),
    .watchdog_expired_flag(watchdog_expired_flag),
    .power_down_flag(power_down_flag));
